/* File: ptc_defines.vh */
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH

// register addresses
`define ADDR_CH1_LEN_LOW    12'h548
`define ADDR_CH1_LEN_HIGH   12'h549
`define ADDR_CH2_LEN_LOW    12'h54A
`define ADDR_CH2_LEN_HIGH   12'h54B
`define ADDR_CH1_SRC_A      12'h550
`define ADDR_CH1_DST_A      12'h551
`define ADDR_CH1_SRC_B      12'h552
`define ADDR_CH1_DST_B      12'h553
`define ADDR_CH2_SRC_A      12'h554
`define ADDR_CH2_DST_A      12'h555
`define ADDR_CH2_SRC_B      12'h556
`define ADDR_CH2_DST_B      12'h557
`define ADDR_WRITE_GUARD    12'h56E

// reset values
`define RST_LEN_LOW         8'hDC
`define RST_LEN_HIGH        6'h05
`define RST_XLATE           7'h00
`define UNLOCK_VALUE        8'hBB

// bit length unit, picoseconds per count
`define LEN_UNIT_PS         16'h1A0A

`endif

/* File: addr_translate.v */
// replaces a 7-bit device address when it matches pair a or pair b
module addr_translate (
   // configuration
   input  wire [6:0] match_a,
   input  wire [6:0] replace_a,
   input  wire [6:0] match_b,
   input  wire [6:0] replace_b,
   // transaction address byte
   input  wire [7:0] addr_in,
   output reg  [7:0] addr_out,
   output reg        hit
);
   always @* begin
      // compare address bits only; direction bit kept
      if (addr_in[7:1] == match_a) begin
         addr_out = {replace_a, addr_in[0]};
         hit      = 1'b1;
      end else if (addr_in[7:1] == match_b) begin
         addr_out = {replace_b, addr_in[0]};
         hit      = 1'b1;
      end else begin
         addr_out = addr_in;
         hit      = 1'b0;
      end
   end
endmodule // addr_translate

/* File: bit_len_select.v */
// chooses the custom or automatic uart bit length of one channel
module bit_len_select (
   input  wire        manual_len_select,
   input  wire [7:0]  custom_len_low,
   input  wire [5:0]  custom_len_high,
   input  wire [13:0] auto_len,
   output wire [13:0] bit_len
);
   assign bit_len = manual_len_select ? {custom_len_high, custom_len_low} : auto_len;
endmodule // bit_len_select

/* File: passthrough_channel_config.v */
`include "ptc_defines.vh"

// Operation
// - per-channel 14-bit custom length, 6.666 ns units
// - custom length used only with manual flag
// - length resets to low 0xDC, high 0b000101
// - matching address replaced by paired destination
// - two independent pairs A and B per channel
// - each channel translates with its own pairs
// - 7-bit addresses in bits 7:1, reset 0x00
// - port fields writable only while key is 0xBB
// - guarded: local disable, both i2c, both uart enables
// - key resets to unlocking value 0xBB
module passthrough_channel_config (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // register access port
   input  wire [11:0] reg_addr,
   input  wire        reg_write,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   // port control field writes
   input  wire        port_ctrl_write,
   input  wire [4:0]  port_ctrl_wdata,
   output reg         local_ctrl_channel_off,
   output reg         twowire_chan1_on,
   output reg         twowire_chan2_on,
   output reg         uart_chan1_on,
   output reg         uart_chan2_on,
   output wire        port_write_open,
   // uart bit length
   input  wire        chan1_manual_len_select,
   input  wire        chan2_manual_len_select,
   input  wire [13:0] chan1_auto_len,
   input  wire [13:0] chan2_auto_len,
   output reg  [13:0] chan1_bit_len,
   output reg  [13:0] chan2_bit_len,
   // i2c address translation
   input  wire [7:0]  chan1_addr_in,
   input  wire [7:0]  chan2_addr_in,
   output reg  [7:0]  chan1_addr_out,
   output reg  [7:0]  chan2_addr_out,
   output reg         chan1_addr_hit,
   output reg         chan2_addr_hit
);

   // register index codes, one per mapped byte address
   localparam [3:0] SEL_CH1_LEN_LOW  = 4'h0;
   localparam [3:0] SEL_CH1_LEN_HIGH = 4'h1;
   localparam [3:0] SEL_CH2_LEN_LOW  = 4'h2;
   localparam [3:0] SEL_CH2_LEN_HIGH = 4'h3;
   localparam [3:0] SEL_CH1_MATCH_A  = 4'h4;
   localparam [3:0] SEL_CH1_REPL_A   = 4'h5;
   localparam [3:0] SEL_CH1_MATCH_B  = 4'h6;
   localparam [3:0] SEL_CH1_REPL_B   = 4'h7;
   localparam [3:0] SEL_CH2_MATCH_A  = 4'h8;
   localparam [3:0] SEL_CH2_REPL_A   = 4'h9;
   localparam [3:0] SEL_CH2_MATCH_B  = 4'hA;
   localparam [3:0] SEL_CH2_REPL_B   = 4'hB;
   localparam [3:0] SEL_WRITE_GUARD  = 4'hC;
   localparam [3:0] SEL_NONE         = 4'hF;

   // stored configuration
   reg  [7:0]  chan1_custom_len_low;
   reg  [5:0]  chan1_custom_len_high;
   reg  [7:0]  chan2_custom_len_low;
   reg  [5:0]  chan2_custom_len_high;
   reg  [6:0]  chan1_match_addr_a;
   reg  [6:0]  chan1_replace_addr_a;
   reg  [6:0]  chan1_match_addr_b;
   reg  [6:0]  chan1_replace_addr_b;
   reg  [6:0]  chan2_match_addr_a;
   reg  [6:0]  chan2_replace_addr_a;
   reg  [6:0]  chan2_match_addr_b;
   reg  [6:0]  chan2_replace_addr_b;
   reg  [7:0]  port_write_guard;
   wire [13:0] next_chan1_bit_len;
   wire [13:0] next_chan2_bit_len;
   wire [7:0]  next_chan1_addr_out;
   wire [7:0]  next_chan2_addr_out;
   wire        next_chan1_addr_hit;
   wire        next_chan2_addr_hit;
   wire [3:0]  reg_sel;
   reg  [7:0]  next_reg_rdata;

   assign port_write_open = (port_write_guard == `UNLOCK_VALUE);
   assign reg_sel = reg_index(reg_addr);

   // maps a byte address to its register index, shared by writes and reads
   function [3:0] reg_index;
      input [11:0] addr;
      begin
         if (addr == `ADDR_CH1_LEN_LOW) begin
            reg_index = SEL_CH1_LEN_LOW;
         end else if (addr == `ADDR_CH1_LEN_HIGH) begin
            reg_index = SEL_CH1_LEN_HIGH;
         end else if (addr == `ADDR_CH2_LEN_LOW) begin
            reg_index = SEL_CH2_LEN_LOW;
         end else if (addr == `ADDR_CH2_LEN_HIGH) begin
            reg_index = SEL_CH2_LEN_HIGH;
         end else if (addr == `ADDR_CH1_SRC_A) begin
            reg_index = SEL_CH1_MATCH_A;
         end else if (addr == `ADDR_CH1_DST_A) begin
            reg_index = SEL_CH1_REPL_A;
         end else if (addr == `ADDR_CH1_SRC_B) begin
            reg_index = SEL_CH1_MATCH_B;
         end else if (addr == `ADDR_CH1_DST_B) begin
            reg_index = SEL_CH1_REPL_B;
         end else if (addr == `ADDR_CH2_SRC_A) begin
            reg_index = SEL_CH2_MATCH_A;
         end else if (addr == `ADDR_CH2_DST_A) begin
            reg_index = SEL_CH2_REPL_A;
         end else if (addr == `ADDR_CH2_SRC_B) begin
            reg_index = SEL_CH2_MATCH_B;
         end else if (addr == `ADDR_CH2_DST_B) begin
            reg_index = SEL_CH2_REPL_B;
         end else if (addr == `ADDR_WRITE_GUARD) begin
            reg_index = SEL_WRITE_GUARD;
         end else begin
            reg_index = SEL_NONE;
         end
      end
   endfunction

   // translation entry as read back, bit 0 reads zero
   function [7:0] entry_byte;
      input [6:0] entry;
      begin
         entry_byte = {entry, 1'b0};
      end
   endfunction

   // length high part as read back, bits 7:6 read zero
   function [7:0] len_high_byte;
      input [5:0] high;
      begin
         len_high_byte = {2'h0, high};
      end
   endfunction

   // register writes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chan1_custom_len_low  <= `RST_LEN_LOW;
         chan1_custom_len_high <= `RST_LEN_HIGH;
         chan2_custom_len_low  <= `RST_LEN_LOW;
         chan2_custom_len_high <= `RST_LEN_HIGH;
         chan1_match_addr_a    <= `RST_XLATE;
         chan1_replace_addr_a  <= `RST_XLATE;
         chan1_match_addr_b    <= `RST_XLATE;
         chan1_replace_addr_b  <= `RST_XLATE;
         chan2_match_addr_a    <= `RST_XLATE;
         chan2_replace_addr_a  <= `RST_XLATE;
         chan2_match_addr_b    <= `RST_XLATE;
         chan2_replace_addr_b  <= `RST_XLATE;
         port_write_guard      <= `UNLOCK_VALUE;
      end else if (reg_write) begin
         if (reg_sel == SEL_CH1_LEN_LOW) begin
            chan1_custom_len_low <= reg_wdata;
         end else if (reg_sel == SEL_CH1_LEN_HIGH) begin
            chan1_custom_len_high <= reg_wdata[5:0];
         end else if (reg_sel == SEL_CH2_LEN_LOW) begin
            chan2_custom_len_low <= reg_wdata;
         end else if (reg_sel == SEL_CH2_LEN_HIGH) begin
            chan2_custom_len_high <= reg_wdata[5:0];
         end else if (reg_sel == SEL_CH1_MATCH_A) begin
            chan1_match_addr_a <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH1_REPL_A) begin
            chan1_replace_addr_a <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH1_MATCH_B) begin
            chan1_match_addr_b <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH1_REPL_B) begin
            chan1_replace_addr_b <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH2_MATCH_A) begin
            chan2_match_addr_a <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH2_REPL_A) begin
            chan2_replace_addr_a <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH2_MATCH_B) begin
            chan2_match_addr_b <= reg_wdata[7:1];
         end else if (reg_sel == SEL_CH2_REPL_B) begin
            chan2_replace_addr_b <= reg_wdata[7:1];
         end else if (reg_sel == SEL_WRITE_GUARD) begin
            port_write_guard <= reg_wdata;
         end
      end
   end

   // guarded port control fields, reset enabled except local disable
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         local_ctrl_channel_off <= 1'b0;
         twowire_chan1_on       <= 1'b1;
         twowire_chan2_on       <= 1'b1;
         uart_chan1_on          <= 1'b1;
         uart_chan2_on          <= 1'b1;
      end else if (port_ctrl_write && port_write_open) begin
         local_ctrl_channel_off <= port_ctrl_wdata[0];
         twowire_chan1_on       <= port_ctrl_wdata[1];
         twowire_chan2_on       <= port_ctrl_wdata[2];
         uart_chan1_on          <= port_ctrl_wdata[3];
         uart_chan2_on          <= port_ctrl_wdata[4];
      end
   end

   // next read byte, unmapped reads zero
   always @* begin
      if (reg_sel == SEL_CH1_LEN_LOW) begin
         next_reg_rdata = chan1_custom_len_low;
      end else if (reg_sel == SEL_CH1_LEN_HIGH) begin
         next_reg_rdata = len_high_byte(chan1_custom_len_high);
      end else if (reg_sel == SEL_CH2_LEN_LOW) begin
         next_reg_rdata = chan2_custom_len_low;
      end else if (reg_sel == SEL_CH2_LEN_HIGH) begin
         next_reg_rdata = len_high_byte(chan2_custom_len_high);
      end else if (reg_sel == SEL_CH1_MATCH_A) begin
         next_reg_rdata = entry_byte(chan1_match_addr_a);
      end else if (reg_sel == SEL_CH1_REPL_A) begin
         next_reg_rdata = entry_byte(chan1_replace_addr_a);
      end else if (reg_sel == SEL_CH1_MATCH_B) begin
         next_reg_rdata = entry_byte(chan1_match_addr_b);
      end else if (reg_sel == SEL_CH1_REPL_B) begin
         next_reg_rdata = entry_byte(chan1_replace_addr_b);
      end else if (reg_sel == SEL_CH2_MATCH_A) begin
         next_reg_rdata = entry_byte(chan2_match_addr_a);
      end else if (reg_sel == SEL_CH2_REPL_A) begin
         next_reg_rdata = entry_byte(chan2_replace_addr_a);
      end else if (reg_sel == SEL_CH2_MATCH_B) begin
         next_reg_rdata = entry_byte(chan2_match_addr_b);
      end else if (reg_sel == SEL_CH2_REPL_B) begin
         next_reg_rdata = entry_byte(chan2_replace_addr_b);
      end else if (reg_sel == SEL_WRITE_GUARD) begin
         next_reg_rdata = port_write_guard;
      end else begin
         next_reg_rdata = 8'h00;
      end
   end

   // read data leaves from a flop, one cycle after the address
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   bit_len_select u_len1 (
      .manual_len_select (chan1_manual_len_select),
      .custom_len_low    (chan1_custom_len_low),
      .custom_len_high   (chan1_custom_len_high),
      .auto_len          (chan1_auto_len),
      .bit_len           (next_chan1_bit_len)
   );

   bit_len_select u_len2 (
      .manual_len_select (chan2_manual_len_select),
      .custom_len_low    (chan2_custom_len_low),
      .custom_len_high   (chan2_custom_len_high),
      .auto_len          (chan2_auto_len),
      .bit_len           (next_chan2_bit_len)
   );

   // each channel owns its pairs
   addr_translate u_xl1 (
      .match_a   (chan1_match_addr_a),
      .replace_a (chan1_replace_addr_a),
      .match_b   (chan1_match_addr_b),
      .replace_b (chan1_replace_addr_b),
      .addr_in   (chan1_addr_in),
      .addr_out  (next_chan1_addr_out),
      .hit       (next_chan1_addr_hit)
   );

   addr_translate u_xl2 (
      .match_a   (chan2_match_addr_a),
      .replace_a (chan2_replace_addr_a),
      .match_b   (chan2_match_addr_b),
      .replace_b (chan2_replace_addr_b),
      .addr_in   (chan2_addr_in),
      .addr_out  (next_chan2_addr_out),
      .hit       (next_chan2_addr_hit)
   );

   // registered data outputs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chan1_bit_len  <= 14'h0000;
         chan2_bit_len  <= 14'h0000;
         chan1_addr_out <= 8'h00;
         chan2_addr_out <= 8'h00;
         chan1_addr_hit <= 1'b0;
         chan2_addr_hit <= 1'b0;
      end else begin
         chan1_bit_len  <= next_chan1_bit_len;
         chan2_bit_len  <= next_chan2_bit_len;
         chan1_addr_out <= next_chan1_addr_out;
         chan2_addr_out <= next_chan2_addr_out;
         chan1_addr_hit <= next_chan1_addr_hit;
         chan2_addr_hit <= next_chan2_addr_hit;
      end
   end

endmodule // passthrough_channel_config

/* File: ptc_props.sv */
module ptc_props (
   // clock, reset and register port
   input wire        clk,
   input wire        reset_n,
   input wire [11:0] reg_addr,
   input wire        reg_write,
   input wire [7:0]  reg_wdata,
   input wire [7:0]  reg_rdata,
   // guarded port fields
   input wire        port_ctrl_write,
   input wire [4:0]  port_ctrl_wdata,
   input wire        local_ctrl_channel_off, twowire_chan1_on, twowire_chan2_on, uart_chan1_on, uart_chan2_on,
   input wire        port_write_open,
   // bit length and translation
   input wire        chan1_manual_len_select, chan2_manual_len_select,
   input wire [13:0] chan1_auto_len, chan2_auto_len, chan1_bit_len, chan2_bit_len,
   input wire [7:0]  chan1_addr_in, chan2_addr_in, chan1_addr_out, chan2_addr_out,
   input wire        chan1_addr_hit, chan2_addr_hit
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire [4:0] en = {uart_chan2_on, uart_chan1_on, twowire_chan2_on, twowire_chan1_on, local_ctrl_channel_off};
   sequence s_open_write;
      port_ctrl_write && port_write_open;
   endsequence
   sequence s_key_write;
      reg_write && reg_addr == 12'h56E;
   endsequence
   a_open_write_lands: assert property (s_open_write |=> en == $past(port_ctrl_wdata))
      else $error("accepted port write not applied");
   a_locked_write_held: assert property (port_ctrl_write && !port_write_open |=> $stable(en))
      else $error("locked port fields changed");
   a_key_opens_port: assert property (s_key_write |=> port_write_open == ($past(reg_wdata) == 8'hBB))
      else $error("guard state wrong after key write");
   a_auto_len_one: assert property (!chan1_manual_len_select |=> chan1_bit_len == $past(chan1_auto_len))
      else $error("channel 1 automatic length not used");
   a_auto_len_two: assert property (!chan2_manual_len_select |=> chan2_bit_len == $past(chan2_auto_len))
      else $error("channel 2 automatic length not used");
   a_miss_passes_through: assert property (1'b1 |=> (chan1_addr_hit || chan1_addr_out == $past(chan1_addr_in))
      && (chan2_addr_hit || chan2_addr_out == $past(chan2_addr_in))) else $error("unmatched address altered");
   a_dir_bit_kept: assert property (1'b1 |=> chan1_addr_out[0] == $past(chan1_addr_in[0])
      && chan2_addr_out[0] == $past(chan2_addr_in[0])) else $error("direction bit altered");
   a_entry_bit_zero: assert property (reg_addr[11:3] == 9'h0AA |=> !reg_rdata[0])
      else $error("translation entry bit 0 not zero");
   a_len_high_narrow: assert property (reg_addr == 12'h549 || reg_addr == 12'h54B |=> reg_rdata[7:6] == 2'b00)
      else $error("length high part wider than six bits");
endmodule // ptc_props

/* File: link_peer.sv */
module link_peer (
   input wire         clk,
   input wire         load,
   input wire  [7:0]  next_addr1,
   input wire  [7:0]  next_addr2,
   output logic [7:0] addr1,
   output logic [7:0] addr2
);
   timeunit 1ns;
   timeprecision 100ps;
   // address byte of the remote transaction on each channel, direction in bit 0
   initial {addr1, addr2} = 16'h0000;
   always @(posedge clk) if (load) {addr1, addr2} <= {next_addr1, next_addr2};
endmodule // link_peer

/* File: passthrough_channel_config_tb.sv */
module passthrough_channel_config_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset_n = 0, reg_write = 0, port_ctrl_write = 0, load = 0, local_ctrl_channel_off, port_write_open;
   logic chan1_manual_len_select = 0, chan2_manual_len_select = 0, chan1_addr_hit, chan2_addr_hit;
   logic twowire_chan1_on, twowire_chan2_on, uart_chan1_on, uart_chan2_on;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, next_addr1 = 8'h00, next_addr2 = 8'h00, lo, hi;
   logic [7:0] chan1_addr_in, chan2_addr_in, chan1_addr_out, chan2_addr_out;
   logic [4:0] port_ctrl_wdata = 5'h00, en_exp = 5'h1E;
   logic [13:0] chan1_auto_len = 14'h0000, chan2_auto_len = 14'h0000, chan1_bit_len, chan2_bit_len;
   logic [6:0] cfg [0:7];
   int miscompares = 0, check_count = 0, p1, p2;
   wire [4:0] en = {uart_chan2_on, uart_chan1_on, twowire_chan2_on, twowire_chan1_on, local_ctrl_channel_off};
   always #12.5 clk = ~clk;
   passthrough_channel_config DUT (
      .clk, .reset_n, .reg_addr, .reg_write, .reg_wdata, .reg_rdata, .port_ctrl_write, .port_ctrl_wdata,
      .local_ctrl_channel_off, .twowire_chan1_on, .twowire_chan2_on, .uart_chan1_on, .uart_chan2_on,
      .port_write_open, .chan1_manual_len_select, .chan2_manual_len_select, .chan1_auto_len, .chan2_auto_len,
      .chan1_bit_len, .chan2_bit_len, .chan1_addr_in, .chan2_addr_in, .chan1_addr_out, .chan2_addr_out,
      .chan1_addr_hit, .chan2_addr_hit
   );
   link_peer peer (.clk, .load, .next_addr1, .next_addr2, .addr1(chan1_addr_in), .addr2(chan2_addr_in));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clk) #1;
      reg_write = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      reg_addr = a;
      @(posedge clk) #1;
      chk(reg_rdata, e);
   endtask
   task automatic pc(input logic [4:0] d, input logic ok);
      port_ctrl_wdata = d;
      chk(port_write_open, ok);
      port_ctrl_write = 1'b1;
      @(posedge clk) #1;
      port_ctrl_write = 1'b0;
      if (ok) en_exp = d;
      chk(en, en_exp);
      @(posedge clk) #1;
   endtask
   function automatic logic [8:0] xl(input logic [7:0] a, input logic [6:0] sa, da, sb, db);
      if (a[7:1] == sa) return {1'b1, da, a[0]};
      if (a[7:1] == sb) return {1'b1, db, a[0]};
      return {1'b0, a};
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      miscompares++;
      final_report;
   end
   initial begin
      p1 = $urandom(32'hA9C96212);
      repeat (8) @(posedge clk);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 8; i++) rd(12'h550 + i, 8'h00);
      for (int i = 0; i < 4; i++) rd(12'h548 + i, i[0] ? 8'h05 : 8'hDC);
      rd(12'h56E, 8'hBB);
      chk(en, 5'h1E);
      wr(12'h560, 8'hFF);
      rd(12'h560, 8'h00);
      for (int n = 0; n < 24; n++) begin
         lo = 8'($urandom);
         hi = (n == 0) ? 8'hFF : 8'($urandom);
         wr(12'h548, lo);
         wr(12'h549, hi);
         wr(12'h54A, ~lo);
         wr(12'h54B, ~hi);
         rd(12'h549, hi & 8'h3F);
         chan1_manual_len_select = n[0];
         chan2_manual_len_select = n[1];
         chan1_auto_len = 14'($urandom);
         chan2_auto_len = 14'($urandom);
         @(posedge clk) #1;
         chk(chan1_bit_len, n[0] ? {hi[5:0], lo} : chan1_auto_len);
         chk(chan2_bit_len, n[1] ? {~hi[5:0], ~lo} : chan2_auto_len);
      end
      pc(5'h15, 1'b1);
      wr(12'h56E, 8'h00);
      pc(5'($urandom), 1'b0);
      wr(12'h56E, 8'hBC);
      pc(5'h0A, 1'b0);
      wr(12'h56E, 8'hBB);
      pc(5'h0A, 1'b1);
      wr(12'h56E, 8'h00);
      reset_n = 1'b0;
      repeat (2) @(posedge clk) #1;
      reset_n = 1'b1;
      rd(12'h56E, 8'hBB);
      chk(en, 5'h1E);
      for (int n = 0; n < 150; n++) begin
         for (int k = 0; k < 8; k++) cfg[k] = 7'($urandom);
         if (n % 7 == 0) {cfg[2], cfg[6]} = {cfg[0], cfg[4]};
         for (int k = 0; k < 8; k++) wr(12'h550 + k, {cfg[k], 1'($urandom)});
         for (int k = 0; k < 8; k++) rd(12'h550 + k, {cfg[k], 1'b0});
         p1 = $urandom_range(4);
         p2 = $urandom_range(4);
         next_addr1 = {p1 ? cfg[2 * p1 - 2] : 7'($urandom), 1'($urandom)};
         next_addr2 = {p2 ? cfg[2 * p2 - 2] : 7'($urandom), 1'($urandom)};
         load = 1'b1;
         @(posedge clk) #1;
         load = 1'b0;
         @(posedge clk) #1;
         chk({chan1_addr_hit, chan1_addr_out}, xl(next_addr1, cfg[0], cfg[1], cfg[2], cfg[3]));
         chk({chan2_addr_hit, chan2_addr_out}, xl(next_addr2, cfg[4], cfg[5], cfg[6], cfg[7]));
      end
      final_report;
   end
endmodule // passthrough_channel_config_tb
bind passthrough_channel_config ptc_props props (
   .clk, .reset_n, .reg_addr, .reg_write, .reg_wdata, .reg_rdata, .port_ctrl_write, .port_ctrl_wdata,
   .local_ctrl_channel_off, .twowire_chan1_on, .twowire_chan2_on, .uart_chan1_on, .uart_chan2_on,
   .port_write_open, .chan1_manual_len_select, .chan2_manual_len_select, .chan1_auto_len, .chan2_auto_len,
   .chan1_bit_len, .chan2_bit_len, .chan1_addr_in, .chan2_addr_in, .chan1_addr_out, .chan2_addr_out,
   .chan1_addr_hit, .chan2_addr_hit
);
